// ==== src/shcp_host_port.sv ====
/*
  Command and status port of a host controller for up to four drives.
  Takes one command at a time from user logic with a request/busy
  handshake, hands it to the drive-side engine and reports presence,
  capacity, block size and errors. The drive-side engine (link, queues,
  buffers) sits outside and talks over the op and scan ports on clk.
*/
// Functional notes
// - Synchronous active-low reset named reset_n
// - Presence vector, one bit per drive slot
// - Presence meaningful only after busy falls
// - Single drive shows bit 0; four show all
// - Shutdown completion clears that drive's presence
// - Target select 0..3 picks drive 0..3
// - Codes: identify, shutdown, write, read, health, flush
// - Busy high while occupied; request only idle
// - Write/read use range; health/flush use words
// - Per-drive capacity, zero until identify completes
// - Unit size flags, zero until identify completes
// - Error flag while cause nonzero, until reset
// - Error device shows drive being operated
// - User data paths are 128 bits wide
// - Identify returns 8 KB, health 512 bytes
// - All drives shut down: inactive until reset
// - No drive at scan sets cause bit 0
`timescale 1ns/100ps
`default_nettype none
module shcp_host_port
  import shcp_pkg::*;
#(
  parameter int DRIVES = NUM_DRIVES,
  parameter int DATA_WIDTH = DATA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // User command
  input wire logic [SEL_W-1:0] targetSelect,
  input wire logic [CODE_W-1:0] commandCode,
  input wire logic [BLOCK_W-1:0] startBlock,
  input wire logic [BLOCK_W-1:0] blockCount,
  input wire logic [CUSTOM_WORDS-1:0][WORD_W-1:0] customSubmissionWords,
  input wire logic request,
  output logic busyFlag,
  // User status
  output logic [NUM_DRIVES-1:0] devicePresent,
  output logic [NUM_DRIVES-1:0][BLOCK_W-1:0] capacityWord,
  output logic [NUM_DRIVES-1:0] unitSizeFlags,
  output logic errorFlag,
  output logic [CAUSE_W-1:0] errorCause,
  output logic [SEL_W-1:0] errorDevice,
  // User RAM write port for identify and health data
  output logic ramWrite,
  output logic [RAM_ADDR_W-1:0] ramAddr,
  output logic [DATA_W-1:0] ramData,
  // Drive scan result
  input wire logic scanDone,
  input wire logic [NUM_DRIVES-1:0] scanPresent,
  // Drive-side operation request
  output logic opStart,
  output logic [CODE_W-1:0] opCode,
  output logic [SEL_W-1:0] opDrive,
  output logic [BLOCK_W-1:0] opStartBlock,
  output logic [BLOCK_W-1:0] opBlockCount,
  output logic opUseCustom,
  output logic [CUSTOM_WORDS-1:0][WORD_W-1:0] opCustomWords,
  // Drive-side operation result
  input wire logic opDone,
  input wire logic [CAUSE_W-1:0] opFault,
  input wire logic [BLOCK_W-1:0] idCapacity,
  input wire logic idLargeUnit,
  input wire logic beatValid,
  input wire logic [DATA_W-1:0] beatData
);

  if (DRIVES != NUM_DRIVES) begin : g_bad_drives
    $error("drive count must match the two-bit target select");
  end
  if (DATA_WIDTH != DATA_W) begin : g_bad_width
    $error("user data path width is fixed");
  end

  shcp_state_type state_ff;
  shcp_state_type nxt_state;
  logic busy_ff;
  logic opStart_ff;
  logic [CODE_W-1:0] opCode_ff;
  logic [SEL_W-1:0] opDrive_ff;
  logic [BLOCK_W-1:0] opStartBlock_ff;
  logic [BLOCK_W-1:0] opBlockCount_ff;
  logic opUseCustom_ff;
  logic [CUSTOM_WORDS-1:0][WORD_W-1:0] opCustom_ff;
  logic [CAUSE_W-1:0] errorCause_ff;
  logic [CAUSE_W-1:0] nxt_errorCause;
  logic errorFlag_ff;
  logic [SEL_W-1:0] errorDevice_ff;
  logic accept;
  logic reserved;
  logic rangeCmd;
  logic customCmd;
  logic finish;
  logic noDrive;
  logic [BEAT_CNT_W-1:0] armLimit;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Command decode
  assign accept = (state_ff == ST_IDLE) && request;
  assign reserved = !(commandCode inside {CMD_IDENTIFY, CMD_SHUTDOWN,
    CMD_WRITE, CMD_READ, CMD_HEALTH, CMD_FLUSH});
  assign rangeCmd = commandCode inside {CMD_WRITE, CMD_READ};
  assign customCmd = commandCode inside {CMD_HEALTH, CMD_FLUSH};
  assign finish = (state_ff == ST_WAIT) && opDone;
  assign noDrive = (state_ff == ST_INIT) && scanDone &&
    (scanPresent == PRESENT_RST);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_INIT: begin
        if (scanDone) begin
          nxt_state = noDrive ? ST_INACTIVE : ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (request) begin
          // Reserved codes are taken but never reach a drive
          nxt_state = reserved ? ST_DONE : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (opDone) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        // Presence already reflects a completed shutdown here
        if (devicePresent == PRESENT_RST) begin
          nxt_state = ST_INACTIVE;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_INACTIVE: begin
        nxt_state = ST_INACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= ST_INIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Busy is low only while waiting in idle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_ff <= 1'b1;
    end else begin
      busy_ff <= (nxt_state != ST_IDLE);
    end
  end

  // Operation launch, one-cycle strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      opStart_ff <= 1'b0;
    end else begin
      opStart_ff <= accept && !reserved;
    end
  end

  // Parameter capture on the accepting cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      opCode_ff <= CMD_IDENTIFY;
      opDrive_ff <= '0;
      opStartBlock_ff <= '0;
      opBlockCount_ff <= '0;
      opUseCustom_ff <= 1'b0;
      opCustom_ff <= '0;
    end else if (accept) begin
      opCode_ff <= commandCode;
      opDrive_ff <= targetSelect;
      opStartBlock_ff <= rangeCmd ? startBlock : '0;
      opBlockCount_ff <= rangeCmd ? blockCount : '0;
      opUseCustom_ff <= customCmd;
      opCustom_ff <= customCmd ? customSubmissionWords : '0;
    end
  end

  // Drive currently being operated
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      errorDevice_ff <= '0;
    end else if (accept) begin
      errorDevice_ff <= targetSelect;
    end
  end

  // Sticky error cause; only reset clears it
  always_comb begin
    nxt_errorCause = errorCause_ff;
    if (noDrive) begin
      nxt_errorCause[ERR_NO_DRIVE] = 1'b1;
    end
    if (finish) begin
      nxt_errorCause = nxt_errorCause | opFault;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      errorCause_ff <= CAUSE_RST;
      errorFlag_ff <= 1'b0;
    end else begin
      errorCause_ff <= nxt_errorCause;
      errorFlag_ff <= (nxt_errorCause != CAUSE_RST);
    end
  end

  // Returned data volume per command
  always_comb begin
    armLimit = NO_LIMIT;
    if (commandCode == CMD_IDENTIFY) begin
      armLimit = IDENT_LIMIT;
    end else if (commandCode == CMD_HEALTH) begin
      armLimit = HEALTH_LIMIT;
    end
  end

  shcp_drive_table u_table (
    .clk(clk),
    .reset_n(reset_n),
    .scanLoad((state_ff == ST_INIT) && scanDone),
    .scanPresent(scanPresent),
    .drive(opDrive_ff),
    .identifyLoad(finish && (opCode_ff == CMD_IDENTIFY)),
    .idCapacity(idCapacity),
    .idLargeUnit(idLargeUnit),
    .shutdownClear(finish && (opCode_ff == CMD_SHUTDOWN)),
    .present(devicePresent),
    .capacity(capacityWord),
    .largeUnit(unitSizeFlags)
  );

  shcp_beat_writer u_beats (
    .clk(clk),
    .reset_n(reset_n),
    .arm(accept),
    .beatLimit(armLimit),
    .beatValid(beatValid),
    .beatData(beatData),
    .ramWrite(ramWrite),
    .ramAddr(ramAddr),
    .ramData(ramData)
  );

  assign busyFlag = busy_ff;
  assign opStart = opStart_ff;
  assign opCode = opCode_ff;
  assign opDrive = opDrive_ff;
  assign opStartBlock = opStartBlock_ff;
  assign opBlockCount = opBlockCount_ff;
  assign opUseCustom = opUseCustom_ff;
  assign opCustomWords = opCustom_ff;
  assign errorCause = errorCause_ff;
  assign errorFlag = errorFlag_ff;
  assign errorDevice = errorDevice_ff;

  sequence seq_accept;
    state_ff == ST_IDLE && request && !reserved;
  endsequence

  sequence seq_launch;
    busyFlag && opStart ##1 busyFlag && !opStart;
  endsequence

  chk_accept_busy: assert property (
    seq_accept |=> seq_launch)
    else $error("accepted command did not raise busy and one start");

  chk_capture_params: assert property (
    seq_accept |=> opDrive == $past(targetSelect) &&
      opCode == $past(commandCode))
    else $error("command parameters not captured at acceptance");

  chk_range_fields: assert property (
    (seq_accept and rangeCmd) |=> opBlockCount == $past(blockCount) &&
      opStartBlock == $past(startBlock) && !opUseCustom)
    else $error("write or read range not forwarded");

  chk_custom_fields: assert property (
    (seq_accept and customCmd) |=> opUseCustom &&
      opCustomWords == $past(customSubmissionWords))
    else $error("custom words not forwarded");

  chk_error_sticky: assert property (
    errorFlag |=> errorFlag && errorCause != CAUSE_RST)
    else $error("error flag dropped without reset");

  chk_error_match: assert property (
    errorFlag == (errorCause != CAUSE_RST))
    else $error("error flag disagrees with cause");

  chk_no_drive_cause: assert property (
    noDrive |=> errorCause[ERR_NO_DRIVE] && errorFlag ##1 busyFlag)
    else $error("empty scan did not flag error");

  chk_error_device: assert property (
    state_ff == ST_IDLE && request |=> errorDevice == $past(targetSelect))
    else $error("operated drive number not shown");

  chk_inactive_hold: assert property (
    state_ff == ST_INACTIVE |=> state_ff == ST_INACTIVE && busyFlag)
    else $error("inactive controller left its state");

  chk_init_busy: assert property (
    state_ff == ST_INIT |-> busyFlag)
    else $error("busy low before scan finished");

endmodule
`default_nettype wire

// ==== src/shcp_pkg.sv ====
/*
  Shared constants for the drive host command port: sizes, command codes,
  reset values, data volumes and controller states.
  Assumes a single 10 MHz clock domain; no other package is needed.
*/
package shcp_pkg;

  // Geometry
  localparam int NUM_DRIVES = 4;
  localparam int SEL_W = 2;
  localparam int CODE_W = 3;
  localparam int BLOCK_W = 48;
  localparam int CAUSE_W = 32;
  localparam int WORD_W = 32;
  localparam int CUSTOM_WORDS = 16;
  localparam int DATA_W = 128;

  // Command codes
  localparam logic [CODE_W-1:0] CMD_IDENTIFY = 3'h0;
  localparam logic [CODE_W-1:0] CMD_SHUTDOWN = 3'h1;
  localparam logic [CODE_W-1:0] CMD_WRITE = 3'h2;
  localparam logic [CODE_W-1:0] CMD_READ = 3'h3;
  localparam logic [CODE_W-1:0] CMD_HEALTH = 3'h4;
  localparam logic [CODE_W-1:0] CMD_FLUSH = 3'h6;

  // Returned data volumes, in bytes and in data beats
  localparam int IDENT_BYTES = 8192;
  localparam int HEALTH_BYTES = 512;
  localparam int BEAT_BYTES = DATA_W / 8;
  localparam int IDENT_BEATS = IDENT_BYTES / BEAT_BYTES;
  localparam int HEALTH_BEATS = HEALTH_BYTES / BEAT_BYTES;
  localparam int RAM_ADDR_W = $clog2(IDENT_BEATS);
  localparam int BEAT_CNT_W = RAM_ADDR_W + 1;
  localparam logic [BEAT_CNT_W-1:0] IDENT_LIMIT = BEAT_CNT_W'(IDENT_BEATS);
  localparam logic [BEAT_CNT_W-1:0] HEALTH_LIMIT = BEAT_CNT_W'(HEALTH_BEATS);
  localparam logic [BEAT_CNT_W-1:0] NO_LIMIT = 10'h000;

  // Error cause bit positions
  localparam int ERR_NO_DRIVE = 0;

  // Reset values
  localparam logic [NUM_DRIVES-1:0] PRESENT_RST = 4'h0;
  localparam logic [BLOCK_W-1:0] CAPACITY_RST = 48'h0;
  localparam logic UNIT_RST = 1'b0;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 32'h0;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_IDLE,
    ST_WAIT,
    ST_DONE,
    ST_INACTIVE
  } shcp_state_type;

endpackage

// ==== src/shcp_drive_table.sv ====
/*
  Per-drive status table: presence, capacity and logical block size.
  Assumes load and clear strobes come from the command controller on clk.
*/
`timescale 1ns/100ps
`default_nettype none
module shcp_drive_table
  import shcp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Scan result
  input wire logic scanLoad,
  input wire logic [NUM_DRIVES-1:0] scanPresent,
  // Command results
  input wire logic [SEL_W-1:0] drive,
  input wire logic identifyLoad,
  input wire logic [BLOCK_W-1:0] idCapacity,
  input wire logic idLargeUnit,
  input wire logic shutdownClear,
  // Table contents
  output logic [NUM_DRIVES-1:0] present,
  output logic [NUM_DRIVES-1:0][BLOCK_W-1:0] capacity,
  output logic [NUM_DRIVES-1:0] largeUnit
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  for (genvar g = 0; g < NUM_DRIVES; g++) begin : g_drive
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        present[g] <= PRESENT_RST[g];
      end else if (scanLoad) begin
        present[g] <= scanPresent[g];
      end else if (shutdownClear && drive == SEL_W'(g)) begin
        present[g] <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        capacity[g] <= CAPACITY_RST;
        largeUnit[g] <= UNIT_RST;
      end else if (identifyLoad && drive == SEL_W'(g)) begin
        capacity[g] <= idCapacity;
        largeUnit[g] <= idLargeUnit;
      end
    end

    chk_shutdown_clears: assert property (
      shutdownClear && !scanLoad && drive == SEL_W'(g) |=> !present[g])
      else $error("shutdown left drive marked present");

    chk_identify_loads: assert property (
      identifyLoad && drive == SEL_W'(g)
        |=> capacity[g] == $past(idCapacity) &&
            largeUnit[g] == $past(idLargeUnit))
      else $error("identify result not stored for drive");
  end

  chk_scan_loads: assert property (
    scanLoad |=> present == $past(scanPresent))
    else $error("scan result not reflected in presence");

endmodule
`default_nettype wire

// ==== src/shcp_beat_writer.sv ====
/*
  Writes returned data beats into the user RAM port, one address per beat,
  capped at the volume armed for the current command.
  Assumes arm and beats arrive on clk; arm is a one-cycle pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module shcp_beat_writer
  import shcp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Command control
  input wire logic arm,
  input wire logic [BEAT_CNT_W-1:0] beatLimit,
  // Incoming beats
  input wire logic beatValid,
  input wire logic [DATA_W-1:0] beatData,
  // RAM write port
  output logic ramWrite,
  output logic [RAM_ADDR_W-1:0] ramAddr,
  output logic [DATA_W-1:0] ramData
);

  logic [BEAT_CNT_W-1:0] count_ff;
  logic [BEAT_CNT_W-1:0] limit_ff;
  logic take;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Beats past the armed volume are dropped
  assign take = beatValid && !arm && (count_ff < limit_ff);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_ff <= NO_LIMIT;
      limit_ff <= NO_LIMIT;
    end else if (arm) begin
      count_ff <= NO_LIMIT;
      limit_ff <= beatLimit;
    end else if (take) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ramWrite <= 1'b0;
      ramAddr <= '0;
      ramData <= '0;
    end else begin
      ramWrite <= take;
      if (take) begin
        ramAddr <= count_ff[RAM_ADDR_W-1:0];
        ramData <= beatData;
      end
    end
  end

  chk_beat_cap: assert property (
    count_ff <= limit_ff)
    else $error("more beats written than armed");

  chk_beat_write: assert property (
    take |=> ramWrite && ramAddr == $past(count_ff[RAM_ADDR_W-1:0]))
    else $error("accepted beat not written at its address");

endmodule
`default_nettype wire

// ==== tb/shcp_engine_model.sv ====
/*
  Drive-side engine model for the host command port: scan, operations and
  returned beats. Assumes the bench keeps its knobs steady during an op.
*/
`timescale 1ns/100ps
`default_nettype none
module shcp_engine_model
  import shcp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Knobs from the bench
  input wire logic [NUM_DRIVES-1:0] found,
  input wire logic [CAUSE_W-1:0] fault,
  input wire logic [7:0] lag,
  // Operation request
  input wire logic opStart,
  input wire logic [CODE_W-1:0] opCode,
  input wire logic [SEL_W-1:0] opDrive,
  // Results
  output logic scanDone,
  output logic [NUM_DRIVES-1:0] scanPresent,
  output logic opDone,
  output logic [CAUSE_W-1:0] opFault,
  output logic [BLOCK_W-1:0] idCapacity,
  output logic idLargeUnit,
  output logic beatValid,
  output logic [DATA_W-1:0] beatData
);
  logic [SEL_W-1:0] drv = 2'h0;
  logic [9:0] idx = 10'h000;
  int n;
  // Idle data lines show the inverse of the last beat
  assign beatData = beatValid ? {8{4'h5, drv, idx}} : ~{8{4'h5, drv, idx}};
  initial begin
    {scanDone, opDone, beatValid, idLargeUnit} = 4'h0;
    scanPresent = 4'h0;
    opFault = 32'h0;
    idCapacity = 48'h0;
  end
  always begin
    @(posedge clk);
    if (!reset_n) begin
      while (!reset_n) @(posedge clk);
      repeat (lag) @(posedge clk);
      scanDone <= 1'b1;
      scanPresent <= found;
      @(posedge clk);
      scanDone <= 1'b0;
      scanPresent <= ~found;
    end else if (opStart) begin
      drv = opDrive;
      n = opCode == CMD_IDENTIFY ? IDENT_BEATS + 2 :
          opCode == CMD_HEALTH ? HEALTH_BEATS + 2 : 0;
      for (int i = 0; i < n; i++) begin
        beatValid <= 1'b1;
        idx <= 10'(i);
        @(posedge clk);
      end
      beatValid <= 1'b0;
      repeat (lag) @(posedge clk);
      opDone <= 1'b1;
      opFault <= fault;
      idCapacity <= 48'h1_0000_0000 | 48'(drv);
      idLargeUnit <= drv[0];
      @(posedge clk);
      opDone <= 1'b0;
      opFault <= 32'h0;
      idCapacity <= ~idCapacity;
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the host command port acting as user logic.
  Assumes the engine model answers every launched operation.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench
  import shcp_pkg::*;
;
  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [SEL_W-1:0] drv;
    logic [BLOCK_W-1:0] sb;
    logic [BLOCK_W-1:0] bc;
    logic uc;
    logic [511:0] cw;
  } shcp_note_type;
  logic clk = 1'b0;
  logic resetN = 1'b0;
  logic [SEL_W-1:0] targetSelect = 2'h0;
  logic [CODE_W-1:0] commandCode = 3'h0;
  logic [BLOCK_W-1:0] startBlock = 48'h0;
  logic [BLOCK_W-1:0] blockCount = 48'h0;
  logic [CUSTOM_WORDS-1:0][WORD_W-1:0] customSubmissionWords = '0;
  logic request = 1'b0;
  logic [3:0] found = 4'hF;
  logic [31:0] fault = 32'h0;
  logic [7:0] lag = 8'h02;
  logic busyFlag, errorFlag, ramWrite, scanDone, opStart, opUseCustom;
  logic opDone, idLargeUnit, beatValid;
  logic [3:0] devicePresent, unitSizeFlags, scanPresent;
  logic [3:0][47:0] capacityWord;
  logic [31:0] errorCause, opFault;
  logic [1:0] errorDevice, opDrive;
  logic [2:0] opCode;
  logic [8:0] ramAddr;
  logic [127:0] ramData, beatData;
  logic [47:0] opStartBlock, opBlockCount, idCapacity;
  logic [511:0] opCustomWords;
  shcp_note_type opQ[$];
  logic [136:0] ramQ[$];
  int n_fail = 0;
  int comparisons = 0;
  int seed = 57;

  shcp_host_port shcp_host_port_i (.clk, .reset_n(resetN), .targetSelect,
    .commandCode, .startBlock, .blockCount, .customSubmissionWords, .request,
    .busyFlag, .devicePresent, .capacityWord, .unitSizeFlags, .errorFlag,
    .errorCause, .errorDevice, .ramWrite, .ramAddr, .ramData, .scanDone,
    .scanPresent, .opStart, .opCode, .opDrive, .opStartBlock, .opBlockCount,
    .opUseCustom, .opCustomWords, .opDone, .opFault, .idCapacity,
    .idLargeUnit, .beatValid, .beatData);
  shcp_engine_model shcp_engine_model_i (.clk, .reset_n(resetN), .found,
    .fault, .lag, .opStart, .opCode, .opDrive, .scanDone, .scanPresent,
    .opDone, .opFault, .idCapacity, .idLargeUnit, .beatValid, .beatData);

  always #50 clk = ~clk;

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chkVal(input string what, input logic [63:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkOp(input shcp_note_type exp, got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] operation expected %h seen %h", exp, got);
    end
  endtask

  task automatic chkRam(input logic [136:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] ram beat expected %h seen %h", exp, got);
    end
  endtask

  task automatic waitBusy(input logic lvl, input int bound);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (busyFlag !== lvl && k < bound);
    if (busyFlag !== lvl) begin
      chkVal("busyFlag wait", 64'(lvl), 64'(busyFlag));
      stop_test();
    end
  endtask

  task automatic resetDut(input logic [3:0] f);
    found <= f;
    resetN <= 1'b0;
    repeat (16) @(posedge clk);
    chkVal("busy in reset", 64'h1, 64'(busyFlag));
    chkVal("present in reset", 64'h0, 64'(devicePresent));
    resetN <= 1'b1;
  endtask

  task automatic issue(input logic [2:0] code, input logic [1:0] sel);
    shcp_note_type e;
    logic [47:0] sb;
    logic [47:0] bc;
    logic [511:0] cw;
    int beats;
    // Start plus count stays below the smallest modelled capacity
    sb = 48'({$random(seed), $random(seed)}) & 48'h0000_7FFF_FFF8;
    bc = 48'(12'($random(seed)) & 12'hFF8) + 48'h8;
    for (int i = 0; i < 16; i++) cw[i*32+:32] = $random(seed);
    e = '{code, sel, 48'h0, 48'h0, 1'b0, 512'h0};
    if (code == CMD_WRITE || code == CMD_READ) begin
      e.sb = sb;
      e.bc = bc;
    end
    if (code == CMD_HEALTH || code == CMD_FLUSH) begin
      e.uc = 1'b1;
      e.cw = cw;
    end
    if (!(code[2] && code[0])) opQ.push_back(e);
    beats = code == CMD_IDENTIFY ? IDENT_BEATS :
            code == CMD_HEALTH ? HEALTH_BEATS : 0;
    for (int i = 0; i < beats; i++) begin
      ramQ.push_back({9'(i), {8{4'h5, sel, 10'(i)}}});
    end
    targetSelect <= sel;
    commandCode <= code;
    startBlock <= sb;
    blockCount <= bc;
    customSubmissionWords <= cw;
    request <= 1'b1;
    waitBusy(1'b1, 4);
    request <= 1'b0;
  endtask

  always @(posedge clk) begin
    if (opStart === 1'b1) begin
      if (opQ.size() == 0) chkVal("stray opStart", 64'h0, 64'h1);
      else chkOp(opQ.pop_front(), {opCode, opDrive, opStartBlock,
        opBlockCount, opUseCustom, opCustomWords});
    end
    if (ramWrite === 1'b1) begin
      if (ramQ.size() == 0) chkVal("stray ramWrite", 64'h0, 64'h1);
      else chkRam(ramQ.pop_front(), {ramAddr, ramData});
    end
  end

  initial begin
    resetDut(4'hF);
    waitBusy(1'b0, 100);
    chkVal("present", 64'hF, 64'(devicePresent));
    chkVal("unit size", 64'h0, 64'(unitSizeFlags));
    chkVal("capacity", 64'h0, 64'(capacityWord[3]));
    for (int d = 0; d < 4; d++) begin
      issue(CMD_IDENTIFY, 2'(d));
      waitBusy(1'b0, 700);
      chkVal("capacity", 64'h1_0000_0000 | 64'(d), 64'(capacityWord[d]));
      chkVal("error device", 64'(d), 64'(errorDevice));
    end
    chkVal("unit size", 64'hA, 64'(unitSizeFlags));
    for (int c = 2; c < 8; c++) begin
      lag <= 8'($random(seed)) & 8'h07;
      issue(3'(c), 2'($random(seed)));
      waitBusy(1'b0, 200);
    end
    fault <= 32'h0000_0010;
    lag <= 8'h28;
    issue(CMD_FLUSH, 2'h2);
    repeat (3) @(posedge clk);
    targetSelect <= 2'h3;
    commandCode <= CMD_READ;
    request <= 1'b1;
    repeat (5) @(posedge clk);
    request <= 1'b0;
    waitBusy(1'b0, 100);
    chkVal("error", 64'h1_0000_0010, 64'({errorFlag, errorCause}));
    chkVal("error device", 64'h2, 64'(errorDevice));
    fault <= 32'h0;
    lag <= 8'h02;
    issue(CMD_READ, 2'h1);
    waitBusy(1'b0, 100);
    chkVal("error held", 64'h1_0000_0010, 64'({errorFlag, errorCause}));
    chkVal("error device", 64'h1, 64'(errorDevice));
    for (int d = 0; d < 4; d++) begin
      issue(CMD_SHUTDOWN, 2'(d));
      if (d < 3) begin
        waitBusy(1'b0, 100);
        chkVal("present", (64'hF << (d + 1)) & 64'hF, 64'(devicePresent));
      end
    end
    repeat (20) @(posedge clk);
    chkVal("inactive", 64'h10, 64'({busyFlag, devicePresent}));
    commandCode <= CMD_IDENTIFY;
    request <= 1'b1;
    repeat (5) @(posedge clk);
    request <= 1'b0;
    repeat (5) @(posedge clk);
    chkVal("inactive busy", 64'h1, 64'(busyFlag));
    resetDut(4'h0);
    repeat (20) @(posedge clk);
    chkVal("empty scan", 64'h3_0000_0001,
      64'({busyFlag, errorFlag, errorCause}));
    resetDut(4'h1);
    waitBusy(1'b0, 100);
    chkVal("single drive", 64'h01, 64'({errorFlag, devicePresent}));
    chkVal("notes left", 64'h0, 64'(opQ.size() + ramQ.size()));
    stop_test();
  end
endmodule
`default_nettype wire
